// >>> rtl/sim_ctrl.sv
// Interrupt status, mode and gain-trim control bank of the light and proximity sensor
//
// Functional notes
// - Power-on or supply glitch sets power-up flag and restores threshold defaults.
// - Any set status flag drives the active-low interrupt pin low.
// - On first silicon revision the power-up flag does not assert the pin.
// - Reading status clears all three flags and releases the interrupt pin.
// - A zero interrupt enable forces and holds its status flag at zero.
// - Ambient flag sets on persisted out-of-window reading or on ambient overflow.
// - Proximity flag sets when reading exceeds threshold longer than persist count.
// - Ambient and proximity flags stick until status read or enable cleared.
// - Power-up flag stays set until status read; config writes never clear it.
// - Trim select 0 uses host trim gains; 1 uses factory gains, ignores writes.
// - Mode 000 shutdown, 001 difference, 010 green only, 011 infrared only.
// - Ambient-only modes neither measure proximity nor update proximity results.
// - Mode 100 interleaves both channels; mode 101 runs proximity only.
// - Enabled ambient overflow sets the ambient flag and pulls interrupt low.
`timescale 1ns/1ps
module sim_ctrl
    import sim_pkg::*;
#(
    parameter bit   FIRST_REV = 1'b0,
    parameter int   GREEN_W   = 7,
    parameter int   IR_W      = 9
) (
    input  wire logic                i_clock,
    input  wire logic                i_rstn,
    input  wire logic                i_supply_glitch,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic [7:0]          i_reg_wdata,
    output logic      [7:0]          o_reg_rdata,
    input  wire logic                i_ambient_valid,
    input  wire logic [13:0]         i_ambient_data,
    input  wire logic                i_ambient_overflow,
    input  wire logic                i_prox_valid,
    input  wire logic [7:0]          i_prox_data,
    input  wire logic [GREEN_W-1:0]  i_factory_green_gain,
    input  wire logic [IR_W-1:0]     i_factory_ir_gain,
    input  wire logic                i_int_n_in,
    output logic                     o_int_n_out,
    output logic                     o_int_n_oe_n,
    output logic                     o_analog_on,
    output logic                     o_ambient_run,
    output logic                     o_proximity_run,
    output sim_pkg::sim_amb_src_t    o_ambient_source,
    output logic [GREEN_W-1:0]       o_green_gain,
    output logic [IR_W-1:0]          o_ir_gain
);
    import sim_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [2:0]   stat_q,    stat_d;
    logic [7:0]   cfg_q,     cfg_d;
    logic [13:0]  up_thr_q,  up_thr_d;
    logic [13:0]  lo_thr_q,  lo_thr_d;
    logic [7:0]   pst_q,     pst_d;
    logic [7:0]   dir_q,     dir_d;
    logic [7:0]   pthr_q,    pthr_d;
    logic [7:0]   gtrim_q,   gtrim_d;
    logic [7:0]   irtrim_q,  irtrim_d;
    logic [7:0]   rdata_q,   rdata_d;
    logic         oe_n_q,    oe_n_d;
    logic         anon_q,    anon_d;
    logic         arun_q,    arun_d;
    logic         prun_q,    prun_d;
    sim_amb_src_t src_q,     src_d;
    logic [GREEN_W-1:0] ggain_q, ggain_d;
    logic [IR_W-1:0]    irgain_q, irgain_d;

    logic [2:0]   mode;
    logic         amb_en;
    logic         prx_en;
    logic         amb_active;
    logic         prx_active;
    logic         amb_out;
    logic         prx_hit;
    logic         amb_fire;
    logic         prx_fire;
    logic         stat_read;
    logic         wr_any;

    assign mode   = cfg_q[CFG_MODE_LSB +: 3];
    assign amb_en = cfg_q[CFG_AMB_EN_BIT];
    assign prx_en = cfg_q[CFG_PRX_EN_BIT];

    function automatic logic wr_hit(input logic [7:0] addr);
        wr_hit = i_reg_wr && (i_reg_addr == addr);
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Reserved codes decode like shutdown so a stray write cannot start a channel
    always_comb begin
        amb_active = 1'b0;
        prx_active = 1'b0;
        src_d      = SIM_SRC_DIFF;
        unique case (mode)
            MODE_AMB_DIFF:  begin amb_active = 1'b1; src_d = SIM_SRC_DIFF;  end
            MODE_AMB_GREEN: begin amb_active = 1'b1; src_d = SIM_SRC_GREEN; end
            MODE_AMB_IR:    begin amb_active = 1'b1; src_d = SIM_SRC_IR;    end
            MODE_AMB_PROX:  begin amb_active = 1'b1; prx_active = 1'b1;     end
            MODE_PROX_ONLY: begin prx_active = 1'b1;                       end
            default:        begin amb_active = 1'b0; prx_active = 1'b0;     end
        endcase
    end

    assign anon_d = amb_active || prx_active;
    assign arun_d = amb_active;
    assign prun_d = prx_active;

    // ------------------------------------------------------------------
    // Threshold compare and persist filters
    // ------------------------------------------------------------------
    assign amb_out = (i_ambient_data > up_thr_q) || (i_ambient_data < lo_thr_q);
    assign prx_hit = i_prox_data > pthr_q;

    sim_persist #(.CNT_W(3)) u_amb_persist (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_sample(i_ambient_valid && amb_active && amb_en),
        .i_hit   (amb_out),
        .i_clear (!amb_active || !amb_en || i_supply_glitch),
        .i_limit (pst_q[PST_AMB_LSB +: 2]),
        .o_fire  (amb_fire)
    );

    sim_persist #(.CNT_W(3)) u_prx_persist (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_sample(i_prox_valid && prx_active && prx_en),
        .i_hit   (prx_hit),
        .i_clear (!prx_active || !prx_en || i_supply_glitch),
        .i_limit (pst_q[PST_PRX_LSB +: 2]),
        .o_fire  (prx_fire)
    );

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    assign stat_read = i_reg_rd && (i_reg_addr == ADDR_IRQ_STATUS);

    // Clear first, then set, so an event in the read cycle survives into the next read
    always_comb begin
        stat_d = stat_q;
        if (stat_read) begin
            stat_d = 3'h0;
        end
        if (amb_fire) begin
            stat_d[STAT_AMB_BIT] = 1'b1;
        end
        if (i_ambient_overflow && amb_active && amb_en) begin
            stat_d[STAT_AMB_BIT] = 1'b1;
        end
        if (prx_fire) begin
            stat_d[STAT_PROX_BIT] = 1'b1;
        end
        if (!cfg_d[CFG_AMB_EN_BIT]) begin
            stat_d[STAT_AMB_BIT] = 1'b0;
        end
        if (!cfg_d[CFG_PRX_EN_BIT]) begin
            stat_d[STAT_PROX_BIT] = 1'b0;
        end
        if (i_supply_glitch) begin
            stat_d[STAT_PWR_BIT] = 1'b1;
        end
    end

    // Pin follows the next flag value so it moves in the same cycle as the status bits
    always_comb begin
        oe_n_d = !(stat_d[STAT_AMB_BIT] || stat_d[STAT_PROX_BIT]
                   || (stat_d[STAT_PWR_BIT] && !FIRST_REV));
    end

    // ------------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------------
    always_comb begin
        cfg_d    = cfg_q;
        up_thr_d = up_thr_q;
        lo_thr_d = lo_thr_q;
        pst_d    = pst_q;
        dir_d    = dir_q;
        pthr_d   = pthr_q;
        gtrim_d  = gtrim_q;
        irtrim_d = irtrim_q;
        if (wr_hit(ADDR_MAIN_CONFIG))  cfg_d  = i_reg_wdata & CFG_MASK;
        if (wr_hit(ADDR_AMB_UPPER_HI)) up_thr_d[13:8] = i_reg_wdata[5:0] & THR_HI_MASK;
        if (wr_hit(ADDR_AMB_UPPER_LO)) up_thr_d[7:0]  = i_reg_wdata;
        if (wr_hit(ADDR_AMB_LOWER_HI)) lo_thr_d[13:8] = i_reg_wdata[5:0] & THR_HI_MASK;
        if (wr_hit(ADDR_AMB_LOWER_LO)) lo_thr_d[7:0]  = i_reg_wdata;
        if (wr_hit(ADDR_PERSIST))      pst_d  = i_reg_wdata & PST_MASK;
        if (wr_hit(ADDR_PROX_DIR))     dir_d  = i_reg_wdata & DIR_MASK;
        if (wr_hit(ADDR_PROX_THR))     pthr_d = i_reg_wdata;
        // Factory gain select locks out writes to the trim bytes; reads still return them
        if (wr_hit(ADDR_GREEN_TRIM) && !cfg_q[CFG_TRIM_BIT]) gtrim_d  = i_reg_wdata;
        if (wr_hit(ADDR_IR_TRIM) && !cfg_q[CFG_TRIM_BIT])    irtrim_d = i_reg_wdata;
        if (i_supply_glitch) begin
            up_thr_d = RST_AMB_THR;
            lo_thr_d = RST_AMB_THR;
            pst_d    = RST_PERSIST;
            dir_d    = RST_PROX_DIR;
            pthr_d   = RST_PROX_THR;
        end
    end

    // ------------------------------------------------------------------
    // Gain select and read mux
    // ------------------------------------------------------------------
    always_comb begin
        if (cfg_q[CFG_TRIM_BIT]) begin
            ggain_d  = i_factory_green_gain;
            irgain_d = i_factory_ir_gain;
        end else begin
            ggain_d  = gtrim_q[7:1];
            irgain_d = {irtrim_q, gtrim_q[0]};
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_IRQ_STATUS:   rdata_d = {5'h00, stat_q};
                ADDR_MAIN_CONFIG:  rdata_d = cfg_q;
                ADDR_AMB_UPPER_HI: rdata_d = {2'h0, up_thr_q[13:8]};
                ADDR_AMB_UPPER_LO: rdata_d = up_thr_q[7:0];
                ADDR_AMB_LOWER_HI: rdata_d = {2'h0, lo_thr_q[13:8]};
                ADDR_AMB_LOWER_LO: rdata_d = lo_thr_q[7:0];
                ADDR_PERSIST:      rdata_d = pst_q;
                ADDR_PROX_DIR:     rdata_d = dir_q;
                ADDR_PROX_THR:     rdata_d = pthr_q;
                ADDR_GREEN_TRIM:   rdata_d = gtrim_q;
                ADDR_IR_TRIM:      rdata_d = irtrim_q;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            stat_q   <= RST_IRQ_STATUS[2:0];
            cfg_q    <= RST_MAIN_CONFIG;
            up_thr_q <= RST_AMB_THR;
            lo_thr_q <= RST_AMB_THR;
            pst_q    <= RST_PERSIST;
            dir_q    <= RST_PROX_DIR;
            pthr_q   <= RST_PROX_THR;
            gtrim_q  <= RST_GREEN_TRIM;
            irtrim_q <= RST_IR_TRIM;
            rdata_q  <= 8'h00;
            oe_n_q   <= FIRST_REV;
            anon_q   <= 1'b0;
            arun_q   <= 1'b0;
            prun_q   <= 1'b0;
            src_q    <= SIM_SRC_DIFF;
            ggain_q  <= '0;
            irgain_q <= '0;
        end else begin
            stat_q   <= stat_d;
            cfg_q    <= cfg_d;
            up_thr_q <= up_thr_d;
            lo_thr_q <= lo_thr_d;
            pst_q    <= pst_d;
            dir_q    <= dir_d;
            pthr_q   <= pthr_d;
            gtrim_q  <= gtrim_d;
            irtrim_q <= irtrim_d;
            rdata_q  <= rdata_d;
            oe_n_q   <= oe_n_d;
            anon_q   <= anon_d;
            arun_q   <= arun_d;
            prun_q   <= prun_d;
            src_q    <= src_d;
            ggain_q  <= ggain_d;
            irgain_q <= irgain_d;
        end
    end

    // Open-drain: the data level is always low, only the enable moves
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_int_n_out <= 1'b0;
        end else begin
            o_int_n_out <= 1'b0;
        end
    end

    assign o_reg_rdata      = rdata_q;
    assign o_int_n_oe_n     = oe_n_q;
    assign o_analog_on      = anon_q;
    assign o_ambient_run    = arun_q;
    assign o_proximity_run  = prun_q;
    assign o_ambient_source = src_q;
    assign o_green_gain     = ggain_q;
    assign o_ir_gain        = irgain_q;

endmodule : sim_ctrl

// >>> rtl/sim_persist.sv
// Persist filter: counts consecutive qualifying readings and fires when the count passes a limit
`timescale 1ns/1ps
module sim_persist #(
    parameter int CNT_W = 3
) (
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    input  wire logic             i_sample,
    input  wire logic             i_hit,
    input  wire logic             i_clear,
    input  wire logic [1:0]       i_limit,
    output logic                  o_fire
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // One reading more than the limit is needed, so limit 0 fires on the first hit
    always_comb begin
        cnt_d  = cnt_q;
        o_fire = 1'b0;
        if (i_clear) begin
            cnt_d = '0;
        end else if (i_sample) begin
            if (!i_hit) begin
                cnt_d = '0;
            end else if (cnt_q >= CNT_W'(i_limit)) begin
                o_fire = 1'b1;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : sim_persist

// >>> rtl/sim_pkg.sv
// Package of register map, field layout, reset values and modes for the sensor control bank
package sim_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_MAIN_CONFIG   = 8'h01;
    localparam logic [7:0] ADDR_AMB_UPPER_HI  = 8'h06;
    localparam logic [7:0] ADDR_AMB_UPPER_LO  = 8'h07;
    localparam logic [7:0] ADDR_AMB_LOWER_HI  = 8'h08;
    localparam logic [7:0] ADDR_AMB_LOWER_LO  = 8'h09;
    localparam logic [7:0] ADDR_PERSIST       = 8'h0a;
    localparam logic [7:0] ADDR_PROX_DIR      = 8'h0b;
    localparam logic [7:0] ADDR_PROX_THR      = 8'h0c;
    localparam logic [7:0] ADDR_GREEN_TRIM    = 8'h0f;
    localparam logic [7:0] ADDR_IR_TRIM       = 8'h10;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_IRQ_STATUS     = 8'h04;
    localparam logic [7:0] RST_MAIN_CONFIG    = 8'h24;
    localparam logic [7:0] RST_PERSIST        = 8'h00;
    localparam logic [7:0] RST_PROX_DIR       = 8'h00;
    localparam logic [7:0] RST_PROX_THR       = 8'h00;
    localparam logic [13:0] RST_AMB_THR       = 14'h0000;
    localparam logic [7:0] RST_GREEN_TRIM     = 8'h80;
    localparam logic [7:0] RST_IR_TRIM        = 8'h80;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int STAT_AMB_BIT   = 0;
    localparam int STAT_PROX_BIT  = 1;
    localparam int STAT_PWR_BIT   = 2;
    localparam int CFG_AMB_EN_BIT = 0;
    localparam int CFG_PRX_EN_BIT = 1;
    localparam int CFG_MODE_LSB   = 2;
    localparam int CFG_TRIM_BIT   = 5;
    localparam int PST_AMB_LSB    = 0;
    localparam int PST_PRX_LSB    = 2;
    localparam int DIR_ABOVE_BIT  = 6;
    localparam logic [7:0] CFG_MASK  = 8'h3f;
    localparam logic [7:0] PST_MASK  = 8'h0f;
    localparam logic [7:0] DIR_MASK  = 8'h40;
    localparam logic [5:0] THR_HI_MASK = 6'h3f;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_SHUTDOWN  = 3'h0;
    localparam logic [2:0] MODE_AMB_DIFF  = 3'h1;
    localparam logic [2:0] MODE_AMB_GREEN = 3'h2;
    localparam logic [2:0] MODE_AMB_IR    = 3'h3;
    localparam logic [2:0] MODE_AMB_PROX  = 3'h4;
    localparam logic [2:0] MODE_PROX_ONLY = 3'h5;

    typedef enum logic [1:0] {
        SIM_SRC_DIFF,
        SIM_SRC_GREEN,
        SIM_SRC_IR
    } sim_amb_src_t;

endpackage : sim_pkg

// >>> verification/sim_ctrl_properties.sv
// Port-level concurrent checks of the sensor control bank
`timescale 1ns/1ps
module sim_ctrl_properties
    import sim_pkg::*;
#(
    parameter bit FIRST_REV = 1'b0,
    parameter int GREEN_W   = 7,
    parameter int IR_W      = 9
) (
    input wire logic                 i_clock,
    input wire logic                 i_rstn,
    input wire logic                 i_supply_glitch,
    input wire logic                 i_reg_wr,
    input wire logic                 i_reg_rd,
    input wire logic [7:0]           i_reg_addr,
    input wire logic [7:0]           i_reg_wdata,
    input wire logic                 i_ambient_valid,
    input wire logic                 i_ambient_overflow,
    input wire logic                 i_prox_valid,
    input wire logic [GREEN_W-1:0]   i_factory_green_gain,
    input wire logic [IR_W-1:0]      i_factory_ir_gain,
    input wire logic                 o_int_n_out,
    input wire logic                 o_int_n_oe_n,
    input wire logic                 o_analog_on,
    input wire logic                 o_ambient_run,
    input wire logic                 o_proximity_run,
    input wire sim_pkg::sim_amb_src_t o_ambient_source,
    input wire logic [GREEN_W-1:0]   o_green_gain,
    input wire logic [IR_W-1:0]      o_ir_gain
);
    // -----------------------------------------------------------------
    // Shadow of the configuration, so decode can be judged from the bus
    // -----------------------------------------------------------------
    logic [7:0] cfg_q, cfg_d;
    logic [1:0] live_q, live_d;
    logic [2:0] mode;
    logic       amb_on, prx_on, steady;
    always_comb begin
        cfg_d  = (i_reg_wr && i_reg_addr == ADDR_MAIN_CONFIG) ? (i_reg_wdata & CFG_MASK) : cfg_q;
        live_d = (live_q == 2'h3) ? live_q : live_q + 2'h1;
    end
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_q  <= RST_MAIN_CONFIG;
            live_q <= 2'h0;
        end else begin
            cfg_q  <= cfg_d;
            live_q <= live_d;
        end
    end
    assign mode   = cfg_q[CFG_MODE_LSB +: 3];
    assign amb_on = (mode >= MODE_AMB_DIFF) && (mode <= MODE_AMB_PROX);
    assign prx_on = (mode == MODE_AMB_PROX) || (mode == MODE_PROX_ONLY);
    // Outputs lag the config by a register, so only a settled config is judged
    assign steady = (live_q == 2'h3);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_pin_drives_low: assert property (o_int_n_out == 1'b0)
        else $error("interrupt pin drive value is not low");
    a_ovf_sets_flag: assert property (i_ambient_overflow && cfg_q[CFG_AMB_EN_BIT]
        && amb_on && !i_reg_wr |=> !o_int_n_oe_n)
        else $error("overflow did not assert interrupt");
    a_read_releases_pin: assert property (i_reg_rd && i_reg_addr == ADDR_IRQ_STATUS
        && !i_supply_glitch && !i_ambient_overflow && !i_ambient_valid && !i_prox_valid
        |=> o_int_n_oe_n) else $error("status read did not release interrupt");
    a_glitch_asserts_pin: assert property (i_supply_glitch
        |=> (FIRST_REV || !o_int_n_oe_n)) else $error("supply glitch did not assert interrupt");
    a_flags_stay_set: assert property (!o_int_n_oe_n && !i_reg_rd && !i_reg_wr
        |=> !o_int_n_oe_n) else $error("interrupt released without read or write");
    a_prox_idle_quiet: assert property (o_int_n_oe_n && !prx_on && !i_ambient_valid
        && !i_ambient_overflow && !i_supply_glitch && !i_reg_wr |=> o_int_n_oe_n)
        else $error("interrupt asserted with proximity inactive");
    a_run_decode: assert property (steady && $stable(cfg_q) |-> o_ambient_run == amb_on
        && o_proximity_run == prx_on && o_analog_on == (amb_on || prx_on))
        else $error("run outputs disagree with mode");
    a_source_decode: assert property (steady && $stable(cfg_q)
        && mode inside {3'h2, 3'h3}
        |-> o_ambient_source == ((mode == MODE_AMB_GREEN) ? SIM_SRC_GREEN : SIM_SRC_IR))
        else $error("ambient source disagrees with mode");
    a_factory_gain: assert property (steady && $stable(cfg_q) && cfg_q[CFG_TRIM_BIT]
        |-> o_green_gain == i_factory_green_gain && o_ir_gain == i_factory_ir_gain)
        else $error("factory gains not selected");
endmodule : sim_ctrl_properties
bind sim_ctrl sim_ctrl_properties #(.FIRST_REV(FIRST_REV), .GREEN_W(GREEN_W), .IR_W(IR_W))
    u_props (.i_clock, .i_rstn, .i_supply_glitch, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .i_ambient_valid, .i_ambient_overflow, .i_prox_valid, .i_factory_green_gain,
    .i_factory_ir_gain, .o_int_n_out, .o_int_n_oe_n, .o_analog_on, .o_ambient_run,
    .o_proximity_run, .o_ambient_source, .o_green_gain, .o_ir_gain);

// >>> verification/sim_ctrl_tb.sv
// Self-checking testbench of the sensor control bank
`timescale 1ns/1ps
module sim_ctrl_tb;
    import sim_pkg::*;
    localparam logic [7:0] RA [7] = '{ADDR_MAIN_CONFIG, ADDR_PERSIST, ADDR_PROX_DIR,
                                      ADDR_PROX_THR, ADDR_GREEN_TRIM, ADDR_IR_TRIM, 8'h05};
    localparam logic [7:0] RV [7] = '{RST_MAIN_CONFIG, RST_PERSIST, RST_PROX_DIR,
                                      RST_PROX_THR, RST_GREEN_TRIM, RST_IR_TRIM, 8'h00};
    logic         i_clock = 1'b0;
    logic         i_rstn  = 1'b0;
    logic         glitch  = 1'b0;
    logic         amb_v   = 1'b0;
    logic         amb_ovf = 1'b0;
    logic         prx_v   = 1'b0;
    logic [13:0]  amb_d   = 14'h0000;
    logic [7:0]   prx_d   = 8'h00;
    logic         wr, rd, pin, int_out, int_oe_n, ana, arun, prun;
    logic [7:0]   addr, wdata, rdata;
    sim_amb_src_t src;
    logic [6:0]   g_gain;
    logic [8:0]   ir_gain;
    int           bad_count = 0;
    int           n_checks  = 0;
    always #2 i_clock = ~i_clock;
    sim_host host (.i_clock, .i_reg_rdata(rdata), .i_int_n_out(int_out), .i_int_n_oe_n(int_oe_n),
        .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_int_pin(pin));
    sim_ctrl dut (.i_clock, .i_rstn, .i_supply_glitch(glitch), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_ambient_valid(amb_v),
        .i_ambient_data(amb_d), .i_ambient_overflow(amb_ovf), .i_prox_valid(prx_v),
        .i_prox_data(prx_d), .i_factory_green_gain(7'h2b), .i_factory_ir_gain(9'h155),
        .i_int_n_in(pin), .o_int_n_out(int_out), .o_int_n_oe_n(int_oe_n), .o_analog_on(ana),
        .o_ambient_run(arun), .o_proximity_run(prun), .o_ambient_source(src),
        .o_green_gain(g_gain), .o_ir_gain(ir_gain));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("register %h", a), {1'b0, e}, {1'b0, d});
    endtask : rdc
    task automatic pin_is(input logic e);
        @(posedge i_clock);
        #1;
        chk("interrupt pin", 9'(e), 9'(pin));
    endtask : pin_is
    task automatic amb(input logic [13:0] d, input logic ovf);
        @(posedge i_clock);
        amb_v   <= !ovf;
        amb_d   <= d;
        amb_ovf <= ovf;
        @(posedge i_clock);
        amb_v   <= 1'b0;
        amb_d   <= ~d;
        amb_ovf <= 1'b0;
    endtask : amb
    task automatic prx(input logic [7:0] d);
        @(posedge i_clock);
        prx_v <= 1'b1;
        prx_d <= d;
        @(posedge i_clock);
        prx_v <= 1'b0;
        prx_d <= ~d;
    endtask : prx
    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        $display("[FAIL] run length expected bounded seen overrun");
        complete_run();
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        pin_is(1'b0);
        rdc(ADDR_IRQ_STATUS, RST_IRQ_STATUS);
        pin_is(1'b1);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        for (int i = 0; i < 7; i++) rdc(RA[i], RV[i]);
        host.wr(ADDR_IRQ_STATUS, 8'hff);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        host.wr(ADDR_GREEN_TRIM, 8'h11);
        rdc(ADDR_GREEN_TRIM, RST_GREEN_TRIM);
        chk("green gain", 9'h02b, 9'(g_gain));
        chk("ir gain", 9'h155, ir_gain);
        for (int m = 0; m < 6; m++) begin
            host.wr(ADDR_MAIN_CONFIG, {3'b001, 3'(m), 2'b00});
            repeat (2) @(posedge i_clock);
            #1;
            chk("analog on", 9'(m != 0), 9'(ana));
            chk("ambient run", 9'(m >= 1 && m <= 4), 9'(arun));
            chk("proximity run", 9'(m >= 4), 9'(prun));
            if (m == 2 || m == 3) begin
                chk("source", 9'((m == 2) ? SIM_SRC_GREEN : SIM_SRC_IR), 9'(src));
            end
        end
        host.wr(ADDR_MAIN_CONFIG, 8'h07);
        host.wr(ADDR_GREEN_TRIM, 8'ha5);
        host.wr(ADDR_IR_TRIM, 8'h3c);
        pin_is(1'b1);
        chk("green gain", 9'h052, 9'(g_gain));
        chk("ir gain", 9'h079, ir_gain);
        host.wr(ADDR_AMB_UPPER_HI, 8'h01);
        host.wr(ADDR_AMB_LOWER_LO, 8'h10);
        host.wr(ADDR_PERSIST, 8'h01);
        host.wr(ADDR_PROX_THR, 8'h40);
        amb(14'h0200, 1'b0);
        pin_is(1'b1);
        amb(14'h0050, 1'b0);
        amb(14'h0200, 1'b0);
        pin_is(1'b1);
        amb(14'h0005, 1'b0);
        pin_is(1'b0);
        repeat (3) pin_is(1'b0);
        rdc(ADDR_IRQ_STATUS, 8'h01);
        prx(8'hff);
        pin_is(1'b1);
        host.wr(ADDR_MAIN_CONFIG, 8'h17);
        prx(8'h40);
        pin_is(1'b1);
        prx(8'h41);
        pin_is(1'b0);
        host.wr(ADDR_MAIN_CONFIG, 8'h17);
        pin_is(1'b0);
        rdc(ADDR_IRQ_STATUS, 8'h02);
        prx(8'h80);
        host.wr(ADDR_MAIN_CONFIG, 8'h15);
        pin_is(1'b1);
        prx(8'hff);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        host.wr(ADDR_MAIN_CONFIG, 8'h13);
        amb(14'h0000, 1'b1);
        pin_is(1'b0);
        rdc(ADDR_IRQ_STATUS, 8'h01);
        @(posedge i_clock);
        glitch <= 1'b1;
        @(posedge i_clock);
        glitch <= 1'b0;
        pin_is(1'b0);
        host.wr(ADDR_MAIN_CONFIG, 8'h10);
        pin_is(1'b0);
        rdc(ADDR_PROX_THR, RST_PROX_THR);
        rdc(ADDR_PERSIST, RST_PERSIST);
        rdc(ADDR_AMB_UPPER_HI, {2'h0, RST_AMB_THR[13:8]});
        rdc(ADDR_MAIN_CONFIG, 8'h10);
        rdc(ADDR_IRQ_STATUS, 8'h04);
        pin_is(1'b1);
        complete_run();
    end
endmodule : sim_ctrl_tb

// >>> verification/sim_host.sv
// Host controller model: register bus master and interrupt pin pull-up
`timescale 1ns/1ps
module sim_host
    import sim_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_reg_rdata,
    input  wire logic       i_int_n_out,
    input  wire logic       i_int_n_oe_n,
    output logic            o_reg_wr = 1'b0,
    output logic            o_reg_rd = 1'b0,
    output logic [7:0]      o_reg_addr = 8'h00,
    output logic [7:0]      o_reg_wdata = 8'h00,
    output logic            o_int_pin
);
    // Pull-up wins whenever the bank releases the open-drain pin
    assign o_int_pin = i_int_n_oe_n ? 1'b1 : i_int_n_out;
    // Idle address and data are inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == ADDR_MAIN_CONFIG && d[4:3] == 2'b11) d[3] = 1'b0;
        @(posedge i_clock);
        o_reg_wr    <= 1'b1;
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        @(posedge i_clock);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_reg_rd   <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_clock);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~a;
        @(posedge i_clock);
        d = i_reg_rdata;
    endtask : rd
endmodule : sim_host
